// ### rtl/afs_regs.sv
// Fault configuration/status and clip level registers of the amplifier control port.
// Assumes fault detectors and the shutdown control are async and two-flop synchronised here; the
// upper clip level bits arrive from another register block.

// Operation
// R1 - Two-bit overcurrent scale: 00 full, 01 three quarters, 10 half, 11 quarter.
// R2 - Clock fault flag follows the detector and clears itself when clocks recover.
// R3 - Overcurrent flag latches and halts output until shutdown control toggles.
// R4 - DC error flag latches and halts output until shutdown control toggles.
// R5 - Over-temperature flag latches and halts output until shutdown control toggles.
// R6 - All four fault flags read-only, reset to zero, zero means absent.
// R7 - Fault register bits 7:6 read as zero and ignore writes.
// R8 - Host must not touch reserved addresses 0x09 to 0x0f.
// R9 - Twenty-bit clip threshold built from three fields, high to low.
// R10 - Register 0x10 holds threshold bits 13:6, read and write.
// R11 - Register 0x11 bits 7:2 hold threshold bits 5:0, read and write.
// R12 - Host keeps register 0x11 bits 1:0 at zero.
// R13 - Samples above threshold magnitude are limited; others pass unchanged.
module afs_regs #(
	parameter int SW = 24
) (
	input wire logic clock, // 40 MHz clock
	input wire logic rst, // Synchronous reset
	input wire logic regWrite, // Write strobe
	input wire logic regRead, // Read strobe
	input wire logic [7:0] regAddr, // Register address
	input wire logic [7:0] regWdata, // Write data
	output logic [7:0] regRdata, // Read data
	input wire logic [5:0] clipLevelHigh, // Threshold bits 19:14
	input wire logic clockFaultIn, // Clock fault detector, async
	input wire logic overcurrentIn, // Overcurrent detector, async
	input wire logic outputDcIn, // DC offset detector, async
	input wire logic overtempIn, // Temperature detector, async
	input wire logic speakerShutdownControl, // Shutdown control, async
	output logic [1:0] overcurrentTripScale, // Trip scale code
	output logic outputHalt, // Stop output stage
	output logic [19:0] clipThresholdLevel, // Assembled threshold
	input wire logic sampleValid, // Input sample strobe
	input wire logic signed [SW-1:0] sampleIn, // Input sample
	output logic sampleOutValid, // Output strobe
	output logic signed [SW-1:0] sampleOut // Clipped sample
);
	// ****************************************
	// Input synchronisers
	// ****************************************
	logic [4:0] sync1_q, sync2_q;
	always_ff @(posedge clock) begin
		if (rst) begin
			sync1_q <= '0;
			sync2_q <= '0;
		end else begin
			sync1_q <= {speakerShutdownControl, clockFaultIn, overcurrentIn, outputDcIn, overtempIn};
			sync2_q <= sync1_q;
		end
	end
	wire logic sdSync = sync2_q[4];
	wire logic clkFaultSync = sync2_q[3];
	wire logic [2:0] latchIn = sync2_q[2:0];

	// ****************************************
	// Fault flags
	// ****************************************
	// Toggle means any change of the shutdown level; set wins over the clear
	logic sdPrev_q;
	logic clockFaultFlag_q;
	logic [2:0] latched_q;
	wire logic sdToggle = sdSync ^ sdPrev_q;
	wire logic [2:0] latched_d = latchIn | (sdToggle ? 3'h0 : latched_q); // R3 R4 R5
	always_ff @(posedge clock) begin
		if (rst) begin
			sdPrev_q <= 1'b0;
			clockFaultFlag_q <= 1'b0; // R6
			latched_q <= '0; // R6
		end else begin
			sdPrev_q <= sdSync;
			clockFaultFlag_q <= clkFaultSync; // R2
			latched_q <= latched_d;
		end
	end
	wire logic overcurrentFaultFlag = latched_q[2];
	wire logic outputDcFaultFlag = latched_q[1];
	wire logic overtempFaultFlag = latched_q[0];
	assign outputHalt = clockFaultFlag_q | (|latched_q); // R2 R3 R4 R5

	// ****************************************
	// Writable fields
	// ****************************************
	logic [1:0] scale_q;
	logic [7:0] clipMid_q;
	logic [5:0] clipLow_q;
	logic [1:0] clipLowRsvd_q;
	wire logic wrFault = regWrite && regAddr == afs_pkg::FAULT_ADDR;
	wire logic wrMid = regWrite && regAddr == afs_pkg::CLIP_MID_ADDR;
	wire logic wrLow = regWrite && regAddr == afs_pkg::CLIP_LOW_ADDR;
	always_ff @(posedge clock) begin
		if (rst) begin
			scale_q <= afs_pkg::SCALE_RST; // R1
			clipMid_q <= afs_pkg::CLIP_MID_RST;
			clipLow_q <= afs_pkg::CLIP_LOW_RST;
			clipLowRsvd_q <= afs_pkg::CLIP_LOW_RSVD_RST;
		end else begin
			if (wrFault) begin
				scale_q <= regWdata[afs_pkg::SCALE_LSB +: 2]; // R1 R7
			end
			if (wrMid) begin
				clipMid_q <= regWdata; // R10
			end
			if (wrLow) begin
				clipLow_q <= regWdata[7:afs_pkg::CLIP_LOW_LSB]; // R11
				clipLowRsvd_q <= regWdata[1:0]; // R12
			end
		end
	end
	assign overcurrentTripScale = scale_q; // R1
	assign clipThresholdLevel = {clipLevelHigh, clipMid_q, clipLow_q}; // R9

	// ****************************************
	// Read path
	// ****************************************
	// Reserved 0x09..0x0f and unmapped addresses read zero
	wire logic [7:0] faultRd = {2'h0, scale_q, clockFaultFlag_q, overcurrentFaultFlag, outputDcFaultFlag,
		overtempFaultFlag}; // R6 R7
	wire logic [7:0] rdMux = (regAddr == afs_pkg::FAULT_ADDR) ? faultRd :
		(regAddr == afs_pkg::CLIP_MID_ADDR) ? clipMid_q :
		(regAddr == afs_pkg::CLIP_LOW_ADDR) ? {clipLow_q, clipLowRsvd_q} : 8'h00; // R8
	logic [7:0] rdata_q;
	always_ff @(posedge clock) begin
		if (rst) begin
			rdata_q <= 8'h00;
		end else if (regRead) begin
			rdata_q <= rdMux;
		end
	end
	assign regRdata = rdata_q;

	// ****************************************
	// Clipper datapath
	// ****************************************
	afs_clipper #(.SW(SW)) clipper (
		.clock(clock),
		.rst(rst),
		.clipThreshold(clipThresholdLevel),
		.sampleValid(sampleValid),
		.sampleIn(sampleIn),
		.sampleOutValid(sampleOutValid),
		.sampleOut(sampleOut)
	); // R13

	// ****************************************
	// Checks
	// ****************************************
	property p_scale_write;
		@(posedge clock) disable iff (rst) wrFault |=> overcurrentTripScale == $past(regWdata[5:4]);
	endproperty
	a_scale_write: assert property (p_scale_write) else $error("Trip scale not written"); // R1
	property p_clock_follow;
		@(posedge clock) disable iff (rst) clkFaultSync |=> clockFaultFlag_q;
	endproperty
	a_clock_follow: assert property (p_clock_follow) else $error("Clock fault flag missed"); // R2
	property p_clock_clear;
		@(posedge clock) disable iff (rst) !clkFaultSync |=> !clockFaultFlag_q;
	endproperty
	a_clock_clear: assert property (p_clock_clear) else $error("Clock fault flag stuck"); // R2
	property p_oc_hold;
		@(posedge clock) disable iff (rst) overcurrentFaultFlag && !sdToggle |=> overcurrentFaultFlag && outputHalt;
	endproperty
	a_oc_hold: assert property (p_oc_hold) else $error("Overcurrent flag dropped"); // R3
	property p_dc_hold;
		@(posedge clock) disable iff (rst) outputDcFaultFlag && !sdToggle |=> outputDcFaultFlag;
	endproperty
	a_dc_hold: assert property (p_dc_hold) else $error("DC flag dropped"); // R4
	property p_ot_set;
		@(posedge clock) disable iff (rst) latchIn[0] |=> overtempFaultFlag ##0 outputHalt;
	endproperty
	a_ot_set: assert property (p_ot_set) else $error("Overtemp flag not set"); // R5
	property p_rsvd_zero;
		@(posedge clock) disable iff (rst) regRead && regAddr == afs_pkg::FAULT_ADDR |=>
			regRdata[7:6] == 2'h0 && regRdata[5:4] == $past(overcurrentTripScale);
	endproperty
	a_rsvd_zero: assert property (p_rsvd_zero) else $error("Reserved bits nonzero"); // R7
	property p_mid_read;
		@(posedge clock) disable iff (rst) regRead && regAddr == afs_pkg::CLIP_MID_ADDR |=> regRdata == $past(clipMid_q);
	endproperty
	a_mid_read: assert property (p_mid_read) else $error("Clip middle readback wrong"); // R10
	property p_low_write;
		@(posedge clock) disable iff (rst) wrLow |=> clipThresholdLevel[5:0] == $past(regWdata[7:2]);
	endproperty
	a_low_write: assert property (p_low_write) else $error("Clip low bits not written"); // R11 R9

	// ****************************************
	// Latch set, hold and clear checks, plus register read and write checks
	// ****************************************
	property p_oc_set;
		@(posedge clock) disable iff (rst) latchIn[2] |=> overcurrentFaultFlag && outputHalt;
	endproperty
	a_oc_set: assert property (p_oc_set) else $error("Overcurrent flag not set"); // R3
	property p_oc_clear;
		@(posedge clock) disable iff (rst) sdToggle && !latchIn[2] |=> !overcurrentFaultFlag;
	endproperty
	a_oc_clear: assert property (p_oc_clear) else $error("Overcurrent flag not cleared"); // R3
	property p_dc_set;
		@(posedge clock) disable iff (rst) latchIn[1] |=> outputDcFaultFlag && outputHalt;
	endproperty
	a_dc_set: assert property (p_dc_set) else $error("DC flag not set"); // R4
	property p_dc_clear;
		@(posedge clock) disable iff (rst) sdToggle && !latchIn[1] |=> !outputDcFaultFlag;
	endproperty
	a_dc_clear: assert property (p_dc_clear) else $error("DC flag not cleared"); // R4
	property p_ot_hold;
		@(posedge clock) disable iff (rst) overtempFaultFlag && !sdToggle |=> overtempFaultFlag && outputHalt;
	endproperty
	a_ot_hold: assert property (p_ot_hold) else $error("Overtemp flag dropped"); // R5
	property p_ot_clear;
		@(posedge clock) disable iff (rst) sdToggle && !latchIn[0] |=> !overtempFaultFlag;
	endproperty
	a_ot_clear: assert property (p_ot_clear) else $error("Overtemp flag not cleared"); // R5
	property p_flags_ro;
		@(posedge clock) disable iff (rst) wrFault && !sdToggle && latchIn == 3'h0 |=>
			latched_q == $past(latched_q);
	endproperty
	a_flags_ro: assert property (p_flags_ro) else $error("Fault flags changed by write"); // R6
	property p_low_read;
		@(posedge clock) disable iff (rst) regRead && regAddr == afs_pkg::CLIP_LOW_ADDR |=>
			regRdata[7:2] == $past(clipThresholdLevel[5:0]);
	endproperty
	a_low_read: assert property (p_low_read) else $error("Clip low readback wrong"); // R11
	property p_mid_write;
		@(posedge clock) disable iff (rst) wrMid |=> clipThresholdLevel[13:6] == $past(regWdata);
	endproperty
	a_mid_write: assert property (p_mid_write) else $error("Clip middle bits not written"); // R10 R9
	property p_scale_hold;
		@(posedge clock) disable iff (rst) !wrFault |=> overcurrentTripScale == $past(overcurrentTripScale);
	endproperty
	a_scale_hold: assert property (p_scale_hold) else $error("Trip scale changed without write"); // R1
endmodule

// ### rtl/afs_pkg.sv
// Constants for the fault status and clip level register slice.
// Assumes a simple byte-wide control port with 8-bit addresses.
package afs_pkg;
	// ****************************************
	// Register offsets
	// ****************************************
	localparam logic [7:0] FAULT_ADDR = 8'h08;
	localparam logic [7:0] RSVD_LO_ADDR = 8'h09;
	localparam logic [7:0] RSVD_HI_ADDR = 8'h0f;
	localparam logic [7:0] CLIP_MID_ADDR = 8'h10;
	localparam logic [7:0] CLIP_LOW_ADDR = 8'h11;
	// ****************************************
	// Field positions and resets
	// ****************************************
	localparam int SCALE_LSB = 4;
	localparam int CLK_BIT = 3;
	localparam int OC_BIT = 2;
	localparam int DC_BIT = 1;
	localparam int OT_BIT = 0;
	localparam int CLIP_LOW_LSB = 2;
	localparam logic [1:0] SCALE_RST = 2'h0;
	localparam logic [7:0] CLIP_MID_RST = 8'h01;
	localparam logic [5:0] CLIP_LOW_RST = 6'h01;
	localparam logic [1:0] CLIP_LOW_RSVD_RST = 2'h0;
endpackage

// ### rtl/afs_clipper.sv
// Symmetric sample clipper against a magnitude threshold.
// Assumes signed two's complement samples on the same clock.
module afs_clipper #(
	parameter int SW = 24
) (
	input wire logic clock, // System clock
	input wire logic rst, // Synchronous reset
	input wire logic [19:0] clipThreshold, // Magnitude limit
	input wire logic sampleValid, // Input sample strobe
	input wire logic signed [SW-1:0] sampleIn, // Input sample
	output logic sampleOutValid, // Output strobe
	output logic signed [SW-1:0] sampleOut // Clipped sample
);
	wire logic signed [SW:0] posLim = $signed({{(SW-19){1'b0}}, clipThreshold});
	wire logic signed [SW:0] negLim = -posLim;
	wire logic signed [SW:0] wideIn = {sampleIn[SW-1], sampleIn};
	wire logic signed [SW:0] clipped = (wideIn > posLim) ? posLim : (wideIn < negLim) ? negLim : wideIn; // R13
	logic valid_q;
	logic signed [SW-1:0] out_q;
	always_ff @(posedge clock) begin
		if (rst) begin
			valid_q <= 1'b0;
			out_q <= '0;
		end else begin
			valid_q <= sampleValid;
			if (sampleValid) begin
				out_q <= clipped[SW-1:0];
			end
		end
	end
	assign sampleOutValid = valid_q;
	assign sampleOut = out_q;
endmodule

// ### dv/afs_host.sv
// Host model on the control port: byte writes and reads.
// Assumes strobes are sampled on the rising clock edge.
module afs_host (
	input wire logic clock, // System clock
	output logic regWrite, // Write strobe
	output logic regRead, // Read strobe
	output logic [7:0] regAddr, // Register address
	output logic [7:0] regWdata, // Write data
	input wire logic [7:0] regRdata // Read data
);
	timeunit 1ns;
	timeprecision 100ps;
	initial begin
		regWrite = 1'b0;
		regRead = 1'b0;
		regAddr = 8'h00;
		regWdata = 8'h00;
	end
	// Callers never offer 0x09-0x0f and keep 0x11 bits 1:0 low
	task automatic xfer(input logic wr, input logic [7:0] a, input logic [7:0] d, output logic [7:0] q);
		@(posedge clock);
		#1;
		regWrite = wr;
		regRead = !wr;
		regAddr = a;
		regWdata = d;
		@(posedge clock);
		#1;
		q = regRdata;
		regWrite = 1'b0;
		regRead = 1'b0;
		// Released lines flip so stale values cannot pass
		regAddr = ~a;
		regWdata = ~d;
	endtask
endmodule

// ### dv/amp_fault_status_and_clip_level_regs_test.sv
// Self-checking bench for the fault status and clip level registers.
// Assumes afs_host drives the control port.
module amp_fault_status_and_clip_level_regs_test;
	timeunit 1ns;
	timeprecision 100ps;
	typedef struct packed {logic [7:0] addr; logic [7:0] wdata; logic [7:0] exp;} afs_row_t;
	afs_row_t rows [6] = '{24'h105a5a, 24'h11a4a4, 24'h083f30, 24'h081f10, 24'h082020, 24'h207700};
	logic clock = 1'b0;
	logic rst = 1'b1;
	logic regWrite, regRead, sampleOutValid, outputHalt;
	logic [7:0] regAddr, regWdata, regRdata, q;
	logic [5:0] clipLevelHigh = 6'h2b;
	logic [3:0] faultIn = 4'h0;
	logic speakerShutdownControl = 1'b0;
	logic sampleValid = 1'b0;
	logic signed [23:0] sampleIn = 24'h000000;
	logic signed [23:0] sampleOut;
	logic [1:0] overcurrentTripScale;
	logic [19:0] clipThresholdLevel;
	int errors = 0;
	int compares = 0;
	int cycles = 0;
	int thr, s, e;
	int samp [3] = '{8388607, -8388607, 291};
	afs_regs afs_regs_inst (.clock(clock), .rst(rst), .regWrite(regWrite), .regRead(regRead), .regAddr(regAddr),
		.regWdata(regWdata), .regRdata(regRdata), .clipLevelHigh(clipLevelHigh), .clockFaultIn(faultIn[3]),
		.overcurrentIn(faultIn[2]), .outputDcIn(faultIn[1]), .overtempIn(faultIn[0]),
		.speakerShutdownControl(speakerShutdownControl), .overcurrentTripScale(overcurrentTripScale),
		.outputHalt(outputHalt), .clipThresholdLevel(clipThresholdLevel), .sampleValid(sampleValid),
		.sampleIn(sampleIn), .sampleOutValid(sampleOutValid), .sampleOut(sampleOut));
	afs_host afs_host_inst (.clock(clock), .regWrite(regWrite), .regRead(regRead), .regAddr(regAddr),
		.regWdata(regWdata), .regRdata(regRdata));
	always #12.5 clock = ~clock;
	// Whole run needs about 140 cycles
	always @(posedge clock) begin
		cycles++;
		if (cycles == 3000) begin
			errors++;
			end_sim();
		end
	end
	task automatic chk(input string n, input logic [23:0] ex, input logic [23:0] g);
		compares++;
		if (g !== ex) begin
			errors++;
			$display("ERROR %s expected %h seen %h", n, ex, g);
		end
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] ex);
		afs_host_inst.xfer(1'b0, a, 8'h00, q);
		chk("regRdata", {16'h0, ex}, {16'h0, q});
	endtask
	task automatic end_sim();
		if (errors == 0 && compares > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask
	initial begin
		repeat (20) @(posedge clock);
		#1;
		rst = 1'b0;
		foreach (rows[i]) begin
			afs_host_inst.xfer(1'b1, rows[i].addr, rows[i].wdata, q);
			rd(rows[i].addr, rows[i].exp);
			if (rows[i].addr == 8'h08) begin
				chk("scale", {22'h0, rows[i].exp[5:4]}, {22'h0, overcurrentTripScale});
			end
		end
		thr = int'({clipLevelHigh, 8'h5a, 6'h29});
		chk("threshold", 24'(thr), {4'h0, clipThresholdLevel});
		foreach (samp[i]) begin
			s = samp[i];
			e = (s > thr) ? thr : ((s < -thr) ? -thr : s);
			@(posedge clock);
			#1;
			sampleValid = 1'b1;
			sampleIn = 24'(s);
			@(posedge clock);
			#1;
			sampleValid = 1'b0;
			chk("outValid", 24'h1, {23'h0, sampleOutValid});
			chk("sampleOut", 24'(e), sampleOut);
		end
		@(posedge clock);
		#1;
		chk("outValidLow", 24'h0, {23'h0, sampleOutValid});
		// Flag bit index matches detector index
		for (int b = 0; b < 4; b++) begin
			faultIn[b] = 1'b1;
			repeat (4) @(posedge clock);
			#1;
			chk("halt", 24'h1, {23'h0, outputHalt});
			rd(8'h08, 8'h20 | (8'h01 << b));
			faultIn[b] = 1'b0;
			repeat (5) @(posedge clock);
			rd(8'h08, (b == 3) ? 8'h20 : (8'h20 | (8'h01 << b)));
			chk("haltHeld", (b == 3) ? 24'h0 : 24'h1, {23'h0, outputHalt});
			speakerShutdownControl = ~speakerShutdownControl;
			repeat (5) @(posedge clock);
			rd(8'h08, 8'h20);
			chk("haltFree", 24'h0, {23'h0, outputHalt});
		end
		// Second reset mid-run after registers were changed
		rst = 1'b1;
		repeat (3) @(posedge clock);
		#1;
		rst = 1'b0;
		chk("rdataRst", 24'h0, {16'h0, regRdata});
		chk("haltRst", 24'h0, {23'h0, outputHalt});
		chk("outValidRst", 24'h0, {23'h0, sampleOutValid});
		chk("sampleOutRst", 24'h0, sampleOut);
		rd(8'h08, 8'h00);
		rd(8'h10, 8'h01);
		rd(8'h11, 8'h04);
		chk("scaleRst", 24'h0, {22'h0, overcurrentTripScale});
		end_sim();
	end
endmodule
